// [clkgen_pkg.sv]
// Package for the clock mode, status and stabilization block.
// Assumes an 8-bit register port; offsets are the printed byte addresses.
package clkgen_pkg;
   localparam logic [19:0] OFS_OSC_MODE  = 20'h0FF7A;
   localparam logic [19:0] OFS_CLK_STAT  = 20'h0FFCE;
   localparam logic [19:0] OFS_STAB_TIME = 20'h0FFCF;
   localparam logic [7:0]  RST_OSC_MODE  = 8'h00;
   localparam logic [7:0]  RST_CLK_STAT  = 8'h32;
   localparam logic [7:0]  RST_STAB_TIME = 8'h00;
   localparam logic [7:0]  RST_STANDBY   = 8'h30;
   localparam int          POS_FULL_RATE = 7;
   localparam int          POS_EXT_CLK   = 6;
   localparam int          POS_SUB_STOP  = 7;
   localparam int          POS_CK_HI     = 6;
   localparam int          POS_CK_LO     = 4;
   localparam int          POS_MAIN_STOP = 2;
   localparam int          POS_HALT      = 0;
   localparam int          POS_CST       = 0;
   localparam int          STAB_BASE_EXP = 19;
   localparam logic [19:0] EXT_STAB_CYC  = 20'h00200;

   typedef struct packed {
      logic [19:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } bus_req_s;

   typedef struct packed {
      logic [7:0]  mode_r;
      logic [7:0]  stab_r;
      logic [7:0]  rdata_r;
      logic        div_r;
      logic        main_clk_r;
      logic [2:0]  pin_sync_r;
      logic [2:0]  sub_sync_r;
      logic        sub_prev_r;
      logic [19:0] wait_cnt_r;
      logic        wait_busy_r;
   } clk_state_s;
endpackage : clkgen_pkg

// [clock_mode_status.sv]
// Clock mode selection, clock status readback and stabilization wait timing.
// Assumes standby_control bits come from the standby block; oscillator pins are async.
// Behaviour
// [RULE_01] Oscillation mode register resets to zero, half-rate main clock.
// [RULE_02] Bit 7 picks full oscillator rate, else half rate.
// [RULE_03] Subsystem clock selected makes full-rate setting irrelevant.
// [RULE_04] Full-rate bit is sticky; only reset clears it.
// [RULE_05] Clock status is read-only; bits 2 and 4-7 mirror standby control.
// [RULE_06] Clock status reads 32 hex after reset.
// [RULE_07] CPU clock select: full, /2, /4, /8, or subsystem clock.
// [RULE_08] Main oscillator stop bit: 0 running, 1 stopped.
// [RULE_09] Source status: 0 main clock, 1 subsystem clock.
// [RULE_10] Sub oscillator stop bit: 0 resistor connected, 1 disconnected.
// [RULE_11] Stabilization register resets to zero: resonator, longest wait.
// [RULE_12] External clock bit: 0 resonator, 1 external clock.
// [RULE_13] Wait 2^19 down to 2^12 main cycles, or 512 sub cycles.
// [RULE_14] Software keeps external clock bit low with a resonator.
// [RULE_15] Software sets external clock bit before STOP with external clock.
// [RULE_16] External clock mode takes main clock from main_osc_out only.
// [RULE_17] External source drives main_osc_in and its inverse on main_osc_out.
// [RULE_18] Main system frequency equals oscillator or half of it.
// [RULE_19] Low seven mode bits read zero; writes ignored.
module clock_mode_status
   import clkgen_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [19:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic [7:0]  standby_control,
   input  wire logic        main_osc_in,
   input  wire logic        main_osc_out,
   input  wire logic        sub_osc_in,
   input  wire logic        stab_start,
   output logic             main_clk_tick,
   output logic             cpu_on_sub,
   output logic             osc_enable,
   output logic             ext_clock_mode,
   output logic             stab_waiting
);
   bus_req_s   req;
   clk_state_s s_r;
   clk_state_s s_nxt;
   logic       osc_now;
   logic       osc_prev;
   logic       osc_edge;
   logic       sub_now;
   logic       sub_edge;
   logic [7:0] status;
   logic [4:0] stab_exp;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   always_comb
   begin
      // Oscillator source chosen by the external clock bit
      osc_now  = s_r.stab_r[POS_EXT_CLK] ? s_r.pin_sync_r[2] : s_r.pin_sync_r[1]; // see [RULE_16]
      osc_prev = s_r.main_clk_r;
      osc_edge = (s_r.pin_sync_r[2] == s_r.pin_sync_r[1]) && osc_now && !osc_prev;
      sub_now  = s_r.sub_sync_r[2];
      sub_edge = (s_r.sub_sync_r[2] == s_r.sub_sync_r[1]) && sub_now && !s_r.sub_prev_r;
      status = 8'h00;
      status[7:4] = standby_control[7:4]; // see [RULE_05] [RULE_07] [RULE_10]
      status[POS_MAIN_STOP] = standby_control[POS_MAIN_STOP]; // see [RULE_08]
      status[5] = 1'b1 & standby_control[5];
      status[4] = standby_control[4];
      status[1] = 1'b1;
      status[POS_CST] = standby_control[POS_CK_HI]; // see [RULE_09]
      stab_exp = 5'(STAB_BASE_EXP) - {2'b00, s_r.stab_r[2:0]};
   end

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.pin_sync_r = {s_r.pin_sync_r[1:0],
                          s_r.stab_r[POS_EXT_CLK] ? main_osc_out : main_osc_in};
      s_nxt.sub_sync_r = {s_r.sub_sync_r[1:0], sub_osc_in};
      if (s_r.pin_sync_r[2] == s_r.pin_sync_r[1])
      begin
         s_nxt.main_clk_r = osc_now;
      end
      if (s_r.sub_sync_r[2] == s_r.sub_sync_r[1])
      begin
         s_nxt.sub_prev_r = sub_now;
      end
      if (osc_edge)
      begin
         s_nxt.div_r = ~s_r.div_r; // see [RULE_18]
      end
      // Sticky bit: a write of zero never clears it
      if (req.wr && req.addr == OFS_OSC_MODE)
      begin
         s_nxt.mode_r[POS_FULL_RATE] = s_r.mode_r[POS_FULL_RATE] | req.wdata[7]; // see [RULE_04]
         s_nxt.mode_r[6:0] = 7'h00; // see [RULE_19]
      end
      else if (req.wr && req.addr == OFS_STAB_TIME)
      begin
         s_nxt.stab_r = {1'b0, req.wdata[POS_EXT_CLK], 3'b000, req.wdata[2:0]}; // see [RULE_12]
      end
      if (req.rd)
      begin
         if (req.addr == OFS_OSC_MODE)
         begin
            s_nxt.rdata_r = s_r.mode_r;
         end
         else if (req.addr == OFS_CLK_STAT)
         begin
            s_nxt.rdata_r = status;
         end
         else if (req.addr == OFS_STAB_TIME)
         begin
            s_nxt.rdata_r = s_r.stab_r;
         end
         else
         begin
            s_nxt.rdata_r = 8'h00;
         end
      end
      // Wait counted in main or sub clock cycles per the external clock bit
      if (stab_start)
      begin
         s_nxt.wait_busy_r = 1'b1;
         s_nxt.wait_cnt_r = s_r.stab_r[POS_EXT_CLK] ? EXT_STAB_CYC
                                                     : (20'h00001 << stab_exp); // see [RULE_13]
      end
      else if (s_r.wait_busy_r)
      begin
         if ((s_r.stab_r[POS_EXT_CLK] ? sub_edge : main_clk_tick))
         begin
            if (s_r.wait_cnt_r <= 20'h00001)
            begin
               s_nxt.wait_busy_r = 1'b0;
               s_nxt.wait_cnt_r = 20'h00000;
            end
            else
            begin
               s_nxt.wait_cnt_r = s_r.wait_cnt_r - 20'h00001;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.mode_r <= RST_OSC_MODE; // see [RULE_01]
         s_r.stab_r <= RST_STAB_TIME; // see [RULE_11]
         s_r.rdata_r <= 8'h00;
      end
      else if (ce)
      begin
         s_r <= s_nxt;
      end
   end

   // Full rate ticks on every oscillator edge, half rate on every other; sub clock ignores it
   assign main_clk_tick  = osc_edge && (s_r.mode_r[POS_FULL_RATE] || s_r.div_r); // see [RULE_02]
   assign cpu_on_sub     = standby_control[POS_CK_HI]; // see [RULE_03]
   assign osc_enable     = 1'b1; // Resonator mode keeps oscillator on; see [RULE_14]
   assign ext_clock_mode = s_r.stab_r[POS_EXT_CLK]; // see [RULE_15] [RULE_17]
   assign stab_waiting   = s_r.wait_busy_r;
   assign reg_rdata      = s_r.rdata_r;
endmodule : clock_mode_status

// [clock_mode_status_asserts.sv]
// Checker for clock_mode_status port behaviour.
// Sees only the top ports; one clock domain.
module cms_chk
   import clkgen_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic [19:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [7:0]  standby_control,
   input wire logic        stab_start,
   input wire logic        cpu_on_sub,
   input wire logic        ext_clock_mode,
   input wire logic        stab_waiting
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire wst = reg_wr && ce && reg_addr == OFS_STAB_TIME;
   sequence s_rd(a); reg_rd && ce && reg_addr == a; endsequence
   property p_sub; cpu_on_sub == standby_control[6]; endproperty
   a_sub: assert property (p_sub) else $error("cpu source bit");
   property p_stat; s_rd(OFS_CLK_STAT) |=> {reg_rdata[7:4], reg_rdata[2]}
      == $past({standby_control[7:4], standby_control[2]}); endproperty
   a_stat: assert property (p_stat) else $error("status mirror");
   property p_cst; s_rd(OFS_CLK_STAT) |=> reg_rdata[1:0] == {1'h1, $past(standby_control[6])};
   endproperty
   a_cst: assert property (p_cst) else $error("status low bits");
   property p_mode; s_rd(OFS_OSC_MODE) |=> reg_rdata[6:0] == 7'h00; endproperty
   a_mode: assert property (p_mode) else $error("mode low bits");
   property p_ext; wst |=> ext_clock_mode == $past(reg_wdata[6]); endproperty
   a_ext: assert property (p_ext) else $error("ext bit write");
   property p_exth; !wst |=> $stable(ext_clock_mode); endproperty
   a_exth: assert property (p_exth) else $error("ext bit moved");
   property p_start; stab_start && ce && !stab_waiting |=> stab_waiting; endproperty
   a_start: assert property (p_start) else $error("wait not started");
   // Shortest wait is thousands of cycles, so eight is a safe floor
   property p_len; $rose(stab_waiting) |-> stab_waiting[*8]; endproperty
   a_len: assert property (p_len) else $error("wait too short");
endmodule : cms_chk
bind clock_mode_status cms_chk i_chk (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .standby_control(standby_control), .stab_start(stab_start), .cpu_on_sub(cpu_on_sub),
   .ext_clock_mode(ext_clock_mode), .stab_waiting(stab_waiting));

// [osc_src.sv]
// External clock source on the oscillator pins.
// Free running; in_stuck freezes main_osc_in to show which pin is used.
module osc_src (
   input  wire logic in_stuck,
   output logic      main_osc_in,
   output logic      main_osc_out,
   output logic      sub_osc_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic ph = 1'h0;
   initial sub_osc_in = 1'h0;
   always #100 ph = ~ph;
   always #400 sub_osc_in = ~sub_osc_in;
   assign main_osc_in  = in_stuck ? 1'h0 : ph;
   assign main_osc_out = ~ph;
endmodule : osc_src

// [clock_mode_status_tb_top.sv]
// Self-checking bench for clock_mode_status.
// Assumes osc_src on the pins: 200 ns main period, 800 ns sub period.
module clock_mode_status_tb_top;
   import clkgen_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'h0, rst = 1'h1, ce = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
   logic [19:0] reg_addr = 20'h00000;
   logic [7:0]  reg_wdata = 8'h00, standby_control = RST_STANDBY, reg_rdata;
   logic        stab_start = 1'h0, in_stuck = 1'h0, mi, mo, si, tick, on_sub, osc_en, ext, wt;
   logic [7:0]  sb [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h44, 8'h84};
   int          mismatches = 0, total_checks = 0, cyc = 0, n;
   always #20 clk = ~clk;
   osc_src i_src (.in_stuck(in_stuck), .main_osc_in(mi), .main_osc_out(mo), .sub_osc_in(si));
   clock_mode_status i_dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .standby_control(standby_control), .main_osc_in(mi), .main_osc_out(mo),
      .sub_osc_in(si), .stab_start(stab_start), .main_clk_tick(tick), .cpu_on_sub(on_sub),
      .osc_enable(osc_en), .ext_clock_mode(ext), .stab_waiting(wt));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      if (got !== exp)
         mismatches++;
   endtask : chk
   task chk_rng(input int got, input int exp, input int tol);
      total_checks++;
      if (got < exp - tol || got > exp + tol)
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      if (got < exp - tol || got > exp + tol)
         mismatches++;
   endtask : chk_rng
   task wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr
   task rd(input logic [19:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, exp);
   endtask : rd
   task cnt(input int k);
      n = 0;
      repeat (k)
      begin
         @(posedge clk);
         #1 n += int'(tick === 1'h1);
      end
   endtask : cnt
   // Ext mode counts cycles: 512 sub edges at 20 cycles each
   task t_wait(input logic [7:0] code, input int exp, input int tol);
      wr(OFS_STAB_TIME, code);
      @(posedge clk);
      stab_start <= 1'h1;
      @(posedge clk);
      stab_start <= 1'h0;
      n = 0;
      #1 chk(8'(wt), 8'h01);
      while (wt === 1'h1 && n < 40000)
      begin
         @(posedge clk);
         #1 n += ext ? 1 : int'(tick === 1'h1);
      end
      chk_rng(n, exp, tol);
   endtask : t_wait
   task t_reset;
      rd(OFS_OSC_MODE, 8'h00);
      rd(OFS_CLK_STAT, 8'h32);
      rd(OFS_STAB_TIME, 8'h00);
      chk(8'(osc_en), 8'h01);
      rd(20'h0FF00, 8'h00);
      $display("t_reset done");
   endtask : t_reset
   task t_rate;
      cnt(1000);
      chk_rng(n, 100, 3);
      wr(OFS_OSC_MODE, 8'hFF);
      rd(OFS_OSC_MODE, 8'h80);
      cnt(1000);
      chk_rng(n, 200, 3);
      wr(OFS_OSC_MODE, 8'h00);
      rd(OFS_OSC_MODE, 8'h80);
      $display("t_rate done");
   endtask : t_rate
   task t_status;
      foreach (sb[i])
      begin
         @(posedge clk) standby_control <= sb[i];
         wr(OFS_CLK_STAT, 8'hFF);
         rd(OFS_CLK_STAT, {sb[i][7:4], 1'h0, sb[i][2], 1'h1, sb[i][6]});
         chk(8'(on_sub), 8'(sb[i][6]));
      end
      $display("t_status done");
   endtask : t_status
   task t_stab;
      t_wait(8'h07, 4096, 4);
      t_wait(8'h40, 10240, 60);
      rd(OFS_STAB_TIME, 8'h40);
      @(posedge clk);
      in_stuck <= 1'h1;
      cnt(1000);
      chk_rng(n, 200, 3);
      $display("t_stab done");
   endtask : t_stab
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done
   always @(posedge clk) cyc <= cyc + 1;
   // One process so the timeout is counted before the verdict is printed
   always @(posedge clk)
   begin
      if (cyc == 60000)
      begin
         mismatches++;
         test_done;
      end
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      t_reset;
      t_rate;
      t_status;
      t_stab;
      test_done;
   end
endmodule : clock_mode_status_tb_top
